// file: snfc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - drive flash link in one, two or four lanes, clock at most 60 MHz
// - 512-byte page buffer visible to software, pages programmed one after another
// - page and single-byte program always use one lane
// - address sent as four bytes or three bytes, chosen by configuration
// - reads in single, dual out, dual io, quad out, quad io forms
// - direct window spans 2 Gbit, register reads span full 32-bit space
// - control and status reachable by the system master
// - staging buffer of 128 words of 32 bits shared by reads and programs
// - read bytes land in staging buffer before forwarding to requester
// - software fills whole page first, then controller shifts it out and programs
// - copier reads flash on its own and writes memory words out
// - direct window address becomes flash address, data returned to requester
// - arbiter gives the link to only one of copier and direct window
// - controller generates all command, address and data sequencing itself
// - each transaction is command byte, then address bytes if enabled, then any dummy cycles, then data bytes
module snfc_ctrl
  import snfc_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC,
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // configuration
  input wire logic cfg_addr4,
  input wire snfc_rdmode_t cfg_rd_mode,
  input wire logic [7:0] cfg_dummy,
  // register-driven read and program
  input wire logic pio_start,
  input wire logic pio_prog,
  input wire logic [7:0] pio_opcode,
  input wire logic pio_addr_en,
  input wire logic [31:0] pio_addr,
  input wire logic [LEN_W-1:0] pio_len,
  // staging buffer fill
  input wire logic stage_wr_en,
  input wire logic [BUF_AW-1:0] stage_wr_idx,
  input wire logic [31:0] stage_wr_data,
  // copier
  input wire logic dma_start,
  input wire logic [31:0] dma_src,
  input wire logic [31:0] dma_dst_start,
  input wire logic [31:0] dma_dst_end,
  // direct read window
  input wire logic dr_req,
  input wire logic [DIRECT_AW-1:0] dr_addr,
  input wire logic [BUF_AW-1:0] dr_words_m1,
  // read data stream
  output logic out_valid,
  input wire logic out_ready,
  output snfc_word_t out_word,
  // status
  output logic busy,
  output logic pio_busy,
  output logic dma_busy,
  output logic dr_busy,
  output logic done_pulse,
  // flash link
  output snfc_link_t flash,
  input wire logic [3:0] flash_io_in
);
  localparam logic [7:0] PH_HI = 8'(HALF_CYC - 1);
  localparam logic [7:0] PH_LAST = 8'(2 * HALF_CYC - 1);

  snfc_state_t state_reg;
  logic [7:0] ph_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [7:0] sh_reg;
  logic [2:0] ln_reg;
  logic [2:0] bb_reg;
  logic [1:0] acnt_reg;
  logic [31:0] ash_reg;
  logic [7:0] dcnt_reg;
  logic [LEN_W-1:0] len_reg;
  logic [LEN_W-1:0] bidx_reg;
  logic prog_reg;
  logic addr_en_reg;
  logic [2:0] aln_reg;
  logic [2:0] dln_reg;
  snfc_src_t src_reg;
  logic [31:0] dst_reg;
  logic [BUF_AW-1:0] widx_reg;
  logic [3:0] io_out_reg;
  logic [3:0] io_oe_reg;
  logic [3:0] io_s;
  logic [31:0] stage_mem [BUF_WORDS];

  // latched requests
  logic pend_pio_reg, pend_dma_reg, pend_dr_reg, rr_dma_reg;
  logic [7:0] p_op_reg;
  logic [31:0] p_addr_reg;
  logic p_addr_en_reg, p_prog_reg;
  logic [LEN_W-1:0] p_len_reg;
  logic [31:0] d_src_reg, d_dst_reg, d_end_reg;
  logic [DIRECT_AW-1:0] r_addr_reg;
  logic [BUF_AW-1:0] r_words_reg;
  logic out_valid_reg, busy_reg, done_reg;
  snfc_word_t out_word_reg;

  logic be, byte_done, fin, fl_wr, gnt_pio, gnt_dma, gnt_dr;
  logic [2:0] beats_m1, mode_aln, mode_dln;
  logic [7:0] mode_op, sh_in, tx_first, tx_next;
  logic [LEN_W-1:0] nb, d_clen, r_len;
  logic [31:0] d_rem;
  logic [BUF_AW-1:0] wlast;
  snfc_state_t after_addr;
  logic f_in_ready, f_out_valid, f_out_ready;
  snfc_word_t f_in_data, f_out_data;

  snfc_sync #(.W(4)) u_io_sync (
    .clk(core_clk),
    .arst_n(arst_n),
    .d(flash_io_in),
    .q(io_s)
  );

  always_comb begin
    mode_op = OP_READ;
    mode_aln = LANE1;
    mode_dln = LANE1;
    case (cfg_rd_mode)
      RD_DUAL_OUT: begin mode_op = OP_DUAL_OUT; mode_dln = LANE2; end
      RD_DUAL_IO: begin mode_op = OP_DUAL_IO; mode_aln = LANE2; mode_dln = LANE2; end
      RD_QUAD_OUT: begin mode_op = OP_QUAD_OUT; mode_dln = LANE4; end
      RD_QUAD_IO: begin mode_op = OP_QUAD_IO; mode_aln = LANE4; mode_dln = LANE4; end
      default: mode_op = OP_READ;
    endcase
  end

  always_comb begin
    case (ln_reg)
      LANE2: begin beats_m1 = 3'h3; sh_in = {sh_reg[5:0], io_s[1:0]}; end
      LANE4: begin beats_m1 = 3'h1; sh_in = {sh_reg[3:0], io_s}; end
      default: begin beats_m1 = 3'h7; sh_in = {sh_reg[6:0], io_s[1]}; end
    endcase
  end

  assign be = (ph_reg == PH_LAST);
  assign byte_done = (bb_reg == beats_m1);
  assign nb = bidx_reg + 10'h001;
  assign tx_first = stage_mem[0][7:0];
  assign tx_next = stage_mem[nb[8:2]][{nb[1:0], 3'h0} +: 8];
  assign after_addr = (dcnt_reg != 8'h00) ? ST_DUMMY : ((len_reg != '0) ? ST_DATA : ST_END);
  assign wlast = BUF_AW'((len_reg - 10'h001) >> 2);
  assign fl_wr = (state_reg == ST_DATA) && be && byte_done && !prog_reg;
  assign fin = ((state_reg == ST_END) && (ph_reg == PH_HI) && (prog_reg || len_reg == '0))
             || ((state_reg == ST_DRAIN) && f_in_ready && (widx_reg == wlast));

  // copier chunks never exceed the staging buffer
  assign d_rem = d_end_reg - d_dst_reg;
  assign d_clen = (d_rem >= 32'(PAGE_LEN)) ? PAGE_LEN : d_rem[LEN_W-1:0];
  assign r_len = ({3'h0, r_words_reg} + 10'h001) << 2;

  // register requests first; copier and direct window alternate
  assign gnt_pio = pend_pio_reg;
  assign gnt_dma = !pend_pio_reg && pend_dma_reg && (!pend_dr_reg || !rr_dma_reg);
  assign gnt_dr = !pend_pio_reg && pend_dr_reg && !gnt_dma;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_pio_reg <= 1'h0;
      p_op_reg <= 8'h00;
      p_addr_reg <= 32'h0000_0000;
      p_addr_en_reg <= 1'h0;
      p_prog_reg <= 1'h0;
      p_len_reg <= '0;
    end else begin
      if (pio_start && (!pend_pio_reg || (fin && src_reg == SRC_PIO))) begin
        p_op_reg <= pio_opcode;
        p_addr_reg <= pio_addr;
        p_addr_en_reg <= pio_addr_en;
        p_prog_reg <= pio_prog;
        p_len_reg <= (pio_len > PAGE_LEN) ? PAGE_LEN : pio_len;
        pend_pio_reg <= 1'h1;
      end else if (fin && src_reg == SRC_PIO) begin
        pend_pio_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_dma_reg <= 1'h0;
      d_src_reg <= 32'h0000_0000;
      d_dst_reg <= 32'h0000_0000;
      d_end_reg <= 32'h0000_0000;
    end else begin
      if (dma_start && (dma_dst_end > dma_dst_start)
          && (!pend_dma_reg || (fin && src_reg == SRC_DMA && d_rem == 32'(len_reg)))) begin
        d_src_reg <= dma_src;
        d_dst_reg <= dma_dst_start;
        d_end_reg <= dma_dst_end;
        pend_dma_reg <= 1'h1;
      end else if (fin && src_reg == SRC_DMA) begin
        d_src_reg <= d_src_reg + 32'(len_reg);
        d_dst_reg <= d_dst_reg + 32'(len_reg);
        if (d_rem == 32'(len_reg)) begin
          pend_dma_reg <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_dr_reg <= 1'h0;
      r_addr_reg <= '0;
      r_words_reg <= '0;
    end else begin
      if (dr_req && (!pend_dr_reg || (fin && src_reg == SRC_DIRECT))) begin
        r_addr_reg <= dr_addr;
        r_words_reg <= dr_words_m1;
        pend_dr_reg <= 1'h1;
      end else if (fin && src_reg == SRC_DIRECT) begin
        pend_dr_reg <= 1'h0;
      end
    end
  end

  // link sequencer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ph_reg <= 8'h00;
      sclk_reg <= 1'h0;
      cs_n_reg <= 1'h1;
      sh_reg <= 8'h00;
      ln_reg <= LANE1;
      bb_reg <= 3'h0;
      acnt_reg <= 2'h0;
      ash_reg <= 32'h0000_0000;
      dcnt_reg <= 8'h00;
      len_reg <= '0;
      bidx_reg <= '0;
      prog_reg <= 1'h0;
      addr_en_reg <= 1'h0;
      aln_reg <= LANE1;
      dln_reg <= LANE1;
      src_reg <= SRC_PIO;
      dst_reg <= 32'h0000_0000;
      widx_reg <= '0;
      rr_dma_reg <= 1'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (gnt_pio || gnt_dma || gnt_dr) begin
            state_reg <= ST_CMD;
            cs_n_reg <= 1'h0;
            ph_reg <= 8'h00;
            bb_reg <= 3'h0;
            bidx_reg <= '0;
            ln_reg <= LANE1;
            acnt_reg <= cfg_addr4 ? ADDR4_M1 : ADDR3_M1;
            if (gnt_pio) begin
              src_reg <= SRC_PIO;
              sh_reg <= p_op_reg;
              ash_reg <= cfg_addr4 ? p_addr_reg : {p_addr_reg[23:0], 8'h00};
              addr_en_reg <= p_addr_en_reg;
              len_reg <= p_len_reg;
              prog_reg <= p_prog_reg;
              dcnt_reg <= p_prog_reg ? 8'h00 : cfg_dummy;
              aln_reg <= p_prog_reg ? LANE1 : mode_aln;
              dln_reg <= p_prog_reg ? LANE1 : mode_dln;
              dst_reg <= 32'h0000_0000;
            end else begin
              src_reg <= gnt_dma ? SRC_DMA : SRC_DIRECT;
              rr_dma_reg <= gnt_dma;
              sh_reg <= mode_op;
              addr_en_reg <= 1'h1;
              prog_reg <= 1'h0;
              dcnt_reg <= cfg_dummy;
              aln_reg <= mode_aln;
              dln_reg <= mode_dln;
              if (gnt_dma) begin
                ash_reg <= cfg_addr4 ? d_src_reg : {d_src_reg[23:0], 8'h00};
                len_reg <= d_clen;
                dst_reg <= d_dst_reg;
              end else begin
                ash_reg <= cfg_addr4 ? {4'h0, r_addr_reg} : {r_addr_reg[23:0], 8'h00};
                len_reg <= r_len;
                dst_reg <= {4'h0, r_addr_reg};
              end
            end
          end
        end
        ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA: begin
          ph_reg <= be ? 8'h00 : ph_reg + 8'h01;
          if (ph_reg == PH_HI) begin
            sclk_reg <= 1'h1;
          end
          if (be) begin
            sclk_reg <= 1'h0;
            sh_reg <= sh_in;
            bb_reg <= byte_done ? 3'h0 : bb_reg + 3'h1;
            if (state_reg == ST_DUMMY) begin
              dcnt_reg <= dcnt_reg - 8'h01;
              if (dcnt_reg == 8'h01) begin
                state_reg <= (len_reg != '0) ? ST_DATA : ST_END;
                sh_reg <= 8'h00;
                bb_reg <= 3'h0;
              end
            end else if (byte_done) begin
              case (state_reg)
                ST_CMD: begin
                  if (addr_en_reg) begin
                    state_reg <= ST_ADDR;
                    sh_reg <= ash_reg[31:24];
                    ash_reg <= {ash_reg[23:0], 8'h00};
                    ln_reg <= aln_reg;
                  end else begin
                    state_reg <= after_addr;
                    sh_reg <= prog_reg ? tx_first : 8'h00;
                    ln_reg <= dln_reg;
                  end
                end
                ST_ADDR: begin
                  if (acnt_reg == 2'h0) begin
                    state_reg <= after_addr;
                    sh_reg <= prog_reg ? tx_first : 8'h00;
                    ln_reg <= dln_reg;
                  end else begin
                    acnt_reg <= acnt_reg - 2'h1;
                    sh_reg <= ash_reg[31:24];
                    ash_reg <= {ash_reg[23:0], 8'h00};
                  end
                end
                default: begin
                  bidx_reg <= nb;
                  if (bidx_reg == len_reg - 10'h001) begin
                    state_reg <= ST_END;
                  end else if (prog_reg) begin
                    sh_reg <= tx_next;
                  end
                end
              endcase
            end
          end
        end
        ST_END: begin
          // release after last falling edge; rising select starts the program
          cs_n_reg <= 1'h1;
          ph_reg <= ph_reg + 8'h01;
          if (ph_reg == PH_HI) begin
            ph_reg <= 8'h00;
            widx_reg <= '0;
            state_reg <= (prog_reg || len_reg == '0) ? ST_IDLE : ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (f_in_ready) begin
            widx_reg <= widx_reg + 7'h01;
            if (widx_reg == wlast) begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // shared staging buffer; link writes win, software should not fill while busy
  always_ff @(posedge core_clk) begin
    if (fl_wr) begin
      stage_mem[bidx_reg[8:2]][{bidx_reg[1:0], 3'h0} +: 8] <= sh_in;
    end else if (stage_wr_en) begin
      stage_mem[stage_wr_idx] <= stage_wr_data;
    end
  end

  // pin drive lags the shifter by one cycle, still a cycle ahead of the rising edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_out_reg <= 4'h0;
      io_oe_reg <= 4'h0;
    end else begin
      case (ln_reg)
        LANE2: io_out_reg <= {2'h0, sh_reg[7:6]};
        LANE4: io_out_reg <= sh_reg[7:4];
        default: io_out_reg <= {3'h0, sh_reg[7]};
      endcase
      case (state_reg)
        ST_CMD: io_oe_reg <= 4'h1;
        ST_ADDR: io_oe_reg <= (aln_reg == LANE4) ? 4'hF : ((aln_reg == LANE2) ? 4'h3 : 4'h1);
        ST_DATA: io_oe_reg <= prog_reg ? 4'h1 : 4'h0;
        default: io_oe_reg <= 4'h0;
      endcase
    end
  end

  assign f_in_data = '{src: src_reg, addr: dst_reg + {23'h00_0000, widx_reg, 2'h0},
                       data: stage_mem[widx_reg]};
  assign f_out_ready = !out_valid_reg || out_ready;

  snfc_fifo #(.W($bits(snfc_word_t)), .DEPTH(FIFO_WORDS)) u_out_fifo (
    .clk(core_clk),
    .arst_n(arst_n),
    .in_valid(state_reg == ST_DRAIN),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_reg <= 1'h0;
      out_word_reg <= '0;
      busy_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      if (f_out_ready) begin
        out_valid_reg <= f_out_valid;
        out_word_reg <= f_out_data;
      end
      busy_reg <= (state_reg != ST_IDLE);
      done_reg <= fin;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_word = out_word_reg;
  assign busy = busy_reg;
  assign pio_busy = pend_pio_reg;
  assign dma_busy = pend_dma_reg;
  assign dr_busy = pend_dr_reg;
  assign done_pulse = done_reg;
  assign flash = '{sclk: sclk_reg, cs_n: cs_n_reg, io_out: io_out_reg, io_oe: io_oe_reg};
endmodule

// file: snfc_pkg.sv
package snfc_pkg;

  // clocking of the flash link
  localparam int SYS_CLK_MHZ = 100;
  localparam int SCK_MAX_MHZ = 60;
  localparam int SCK_MIN_HALF = (SYS_CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int SYNC_STAGES = 2;
  // input synchroniser needs two cycles of the low half, so half period never below it
  localparam int SCK_HALF_CYC = (SCK_MIN_HALF > SYNC_STAGES) ? SCK_MIN_HALF : SYNC_STAGES;
  // staging buffer and lengths
  localparam int BUF_WORDS = 128;
  localparam int BUF_AW = 7;
  localparam int PAGE_BYTES = 512;
  localparam int LEN_W = 10;
  localparam logic [LEN_W-1:0] PAGE_LEN = 10'h200;
  localparam int DIRECT_AW = 28;
  localparam int FIFO_DEPTH = 16;
  // opcodes and address sizes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [1:0] ADDR3_M1 = 2'h2;
  localparam logic [1:0] ADDR4_M1 = 2'h3;
  // lane counts
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;

  typedef enum logic [2:0] {
    RD_SINGLE = 3'h0,
    RD_DUAL_OUT = 3'h1,
    RD_DUAL_IO = 3'h2,
    RD_QUAD_OUT = 3'h3,
    RD_QUAD_IO = 3'h4
  } snfc_rdmode_t;

  typedef enum logic [1:0] {
    SRC_PIO = 2'h0,
    SRC_DMA = 2'h1,
    SRC_DIRECT = 2'h2
  } snfc_src_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_DATA = 7'h10,
    ST_END = 7'h20,
    ST_DRAIN = 7'h40
  } snfc_state_t;

  typedef struct packed {
    snfc_src_t src;
    logic [31:0] addr;
    logic [31:0] data;
  } snfc_word_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } snfc_link_t;

endpackage

// file: snfc_sync.sv
`timescale 1ns/1ps
module snfc_sync #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;
endmodule

// file: snfc_fifo.sv
`timescale 1ns/1ps
module snfc_fifo #(
  parameter int W = 66,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  // depth must be a power of two; extra pointer bit tells full from empty
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic full;
  logic empty;

  assign full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty = (wp_reg == rp_reg);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_reg[AW-1:0]];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (!empty && out_ready) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end
endmodule

// file: snfc_flash_model.sv
`timescale 1ns/1ps
module snfc_flash_model (
  // link from the controller
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] mosi,
  // phase setup from the bench
  input wire logic [2:0] alanes,
  input wire logic [2:0] dlanes,
  input wire logic [5:0] abits,
  // answer and capture
  output logic [3:0] miso,
  output logic [7:0] cmd,
  output logic [31:0] addr,
  output logic [31:0] wsh,
  output int dbits
);
  int cnt;
  int rb;
  logic [7:0] cur;
  initial miso = 4'h0;
  always @(negedge cs_n) begin
    cnt = 0;
    rb = 0;
    dbits = 0;
    addr = 32'h0000_0000;
  end
  // released lines never keep their last value
  always @(posedge cs_n) miso = ~miso;
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (cnt < 8) begin
        cmd = {cmd[6:0], mosi[0]};
        cnt++;
      end else if (cnt < 8 + abits) begin
        addr = (addr << alanes) | 32'(mosi & ((4'h1 << alanes) - 4'h1));
        cnt += alanes;
      end else begin
        wsh = {wsh[30:0], mosi[0]};
        dbits++;
      end
    end
  end
  // unused lanes toggle each beat so a stale sample shows up
  always @(negedge sclk) begin
    miso = ~miso;
    if (!cs_n && cnt >= 8 + abits) begin
      cur = (addr[7:0] + 8'(rb / 8)) ^ 8'h5a;
      cur = cur << (rb % 8);
      case (dlanes)
        3'h1: miso[1] = cur[7];
        3'h2: miso[1:0] = cur[7:6];
        default: miso = cur[7:4];
      endcase
      rb += dlanes;
    end
  end
endmodule

// file: snfc_ctrl_checker.sv
`timescale 1ns/1ps
module snfc_ctrl_checker
  import snfc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // requests
  input wire logic pio_start,
  input wire logic dma_start,
  input wire logic [31:0] dma_dst_start,
  input wire logic [31:0] dma_dst_end,
  input wire logic dr_req,
  // status and stream
  input wire logic busy,
  input wire logic pio_busy,
  input wire logic dma_busy,
  input wire logic dr_busy,
  input wire logic done_pulse,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire snfc_word_t out_word,
  // flash link
  input wire snfc_link_t flash
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_pio_taken: assert property (pio_start && !pio_busy |=> pio_busy)
    else $error("pio request not taken");
  a_dma_taken: assert property (dma_start && !dma_busy && dma_dst_end > dma_dst_start |=> dma_busy)
    else $error("copier request not taken");
  a_dma_refused: assert property (dma_start && !dma_busy && dma_dst_end <= dma_dst_start |=> !dma_busy)
    else $error("empty copier range taken");
  a_dr_taken: assert property (dr_req && !dr_busy |=> dr_busy)
    else $error("direct request not taken");
  a_cmd_one_lane: assert property ($fell(flash.cs_n) |=> (flash.io_oe == 4'h1) [*8])
    else $error("command not on one lane");
  a_idle_quiet: assert property (flash.cs_n |-> !flash.sclk && flash.io_oe == 4'h0)
    else $error("link active without select");
  a_sclk_half: assert property ($rose(flash.sclk) |=> flash.sclk ##1 !flash.sclk)
    else $error("serial clock high time wrong");
  a_cs_frame: assert property ($changed(flash.sclk) |-> !flash.cs_n)
    else $error("clock edge outside select");
  a_link_grab: assert property (pio_start && !busy && !dma_busy && !dr_busy |-> ##[1:4] !flash.cs_n)
    else $error("idle link not started");
  a_done_single: assert property (done_pulse |=> !done_pulse)
    else $error("done longer than one cycle");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("stalled word changed");
endmodule
bind snfc_ctrl snfc_ctrl_checker i_snfc_ctrl_checker (.core_clk(core_clk), .arst_n(arst_n),
  .pio_start(pio_start), .dma_start(dma_start), .dma_dst_start(dma_dst_start),
  .dma_dst_end(dma_dst_end), .dr_req(dr_req), .busy(busy), .pio_busy(pio_busy),
  .dma_busy(dma_busy), .dr_busy(dr_busy), .done_pulse(done_pulse), .out_valid(out_valid),
  .out_ready(out_ready), .out_word(out_word), .flash(flash));

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top
  import snfc_pkg::*;
;
  logic core_clk, arst_n, cfg_addr4, pio_start, pio_prog, pio_addr_en, stage_wr_en, dma_start;
  logic dr_req, out_ready, out_valid, busy, pio_busy, dma_busy, dr_busy, done_pulse;
  snfc_rdmode_t cfg_rd_mode;
  logic [7:0] pio_opcode, cmd;
  logic [31:0] pio_addr, stage_wr_data, dma_src, dma_dst_start, dma_dst_end, maddr, wsh;
  logic [LEN_W-1:0] pio_len;
  logic [BUF_AW-1:0] stage_wr_idx, dr_words_m1;
  logic [DIRECT_AW-1:0] dr_addr;
  logic [3:0] miso, io_in;
  logic [2:0] alanes, dlanes;
  logic [5:0] abits;
  snfc_word_t out_word;
  snfc_link_t flash;
  int errors, cmp_count, np, nd, nr, dbits, ndone;
  // pin level from whoever drives it
  assign #1 io_in = (flash.io_oe & flash.io_out) | (~flash.io_oe & miso);
  snfc_ctrl i_snfc_ctrl (.core_clk(core_clk), .arst_n(arst_n), .cfg_addr4(cfg_addr4),
    .cfg_rd_mode(cfg_rd_mode), .cfg_dummy(8'h00), .pio_start(pio_start), .pio_prog(pio_prog),
    .pio_opcode(pio_opcode), .pio_addr_en(pio_addr_en), .pio_addr(pio_addr), .pio_len(pio_len),
    .stage_wr_en(stage_wr_en), .stage_wr_idx(stage_wr_idx), .stage_wr_data(stage_wr_data),
    .dma_start(dma_start), .dma_src(dma_src), .dma_dst_start(dma_dst_start),
    .dma_dst_end(dma_dst_end), .dr_req(dr_req), .dr_addr(dr_addr), .dr_words_m1(dr_words_m1),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .busy(busy),
    .pio_busy(pio_busy), .dma_busy(dma_busy), .dr_busy(dr_busy), .done_pulse(done_pulse),
    .flash(flash), .flash_io_in(io_in));
  snfc_flash_model i_snfc_flash_model (.sclk(flash.sclk), .cs_n(flash.cs_n),
    .mosi(flash.io_out), .alanes(alanes), .dlanes(dlanes), .abits(abits), .miso(miso),
    .cmd(cmd), .addr(maddr), .wsh(wsh), .dbits(dbits));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // done can land while words are still being taken
  always @(posedge core_clk) if (done_pulse === 1'b1) ndone++;
  function automatic logic [31:0] ewd(logic [31:0] a);
    for (int i = 0; i < 4; i++) ewd[8*i +: 8] = (a[7:0] + 8'(i)) ^ 8'h5a;
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 40000 && ndone == 0; i++) step(1);
    step(4);
    chk("done count", 1, ndone);
    chk("busy idle", 0, busy);
    ndone = 0;
  endtask
  task automatic take_word(int n);
    logic [31:0] ea, fa;
    out_ready = 1'b1;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 4000 && out_valid !== 1'b1; i++) step(1);
      case (out_word.src)
        SRC_PIO: begin ea = 32'(4 * np); fa = pio_addr + ea; np++; end
        SRC_DMA: begin ea = dma_dst_start + 32'(4 * nd); fa = dma_src + 32'(4 * nd); nd++; end
        default: begin ea = {4'h0, dr_addr} + 32'(4 * nr); fa = ea; nr++; end
      endcase
      chk("word addr", ea, out_word.addr);
      chk("word data", ewd(fa), out_word.data);
      step(1);
    end
    out_ready = 1'b0;
  endtask
  task automatic pio_go();
    pio_start = 1'b1;
    step(1);
    pio_start = 1'b0;
    chk("pio pend", 1, pio_busy);
  endtask
  task automatic t_pio_read();
    np = 0;
    cfg_addr4 = 1'b1;
    abits = 6'h20;
    pio_opcode = OP_READ;
    pio_addr = 32'hA123_4560;
    pio_len = 10'h008;
    pio_go();
    take_word(2);
    wait_done();
    chk("pio cmd", 32'(OP_READ), 32'(cmd));
    chk("pio addr", pio_addr, maddr);
  endtask
  task automatic t_modes();
    logic [7:0] ops [5] = '{OP_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO};
    logic [2:0] al [5] = '{LANE1, LANE1, LANE2, LANE1, LANE4};
    logic [2:0] dl [5] = '{LANE1, LANE2, LANE2, LANE4, LANE4};
    cfg_addr4 = 1'b0;
    abits = 6'h18;
    dr_words_m1 = 7'h01;
    for (int m = 0; m < 5; m++) begin
      cfg_rd_mode = snfc_rdmode_t'(m);
      alanes = al[m];
      dlanes = dl[m];
      dr_addr = 28'h9AB_C010 + 28'(m * 8);
      nr = 0;
      dr_req = 1'b1;
      step(1);
      dr_req = 1'b0;
      take_word(2);
      wait_done();
      chk("mode cmd", 32'(ops[m]), 32'(cmd));
      chk("mode addr", {8'h00, dr_addr[23:0]}, maddr);
    end
  endtask
  task automatic t_arb();
    cfg_rd_mode = RD_SINGLE;
    alanes = LANE1;
    dlanes = LANE1;
    nd = 0;
    nr = 0;
    dma_src = 32'h0000_0400;
    dma_dst_start = 32'h2000_0000;
    dma_dst_end = 32'h2000_0000;
    dma_start = 1'b1;
    step(1);
    dma_start = 1'b0;
    chk("empty range", 0, dma_busy);
    dma_dst_end = 32'h2000_0040;
    dr_addr = 28'h000_0800;
    dr_words_m1 = 7'h13;
    dma_start = 1'b1;
    dr_req = 1'b1;
    step(1);
    dma_start = 1'b0;
    dr_req = 1'b0;
    chk("both pend", 2, 32'(dma_busy) + 32'(dr_busy));
    step(6000);
    chk("stall hold", 1, out_valid);
    chk("busy stall", 1, busy);
    take_word(36);
    chk("copier words", 16, nd);
    chk("direct words", 20, nr);
    step(50);
    ndone = 0;
  endtask
  task automatic t_prog();
    abits = 6'h18;
    pio_prog = 1'b1;
    pio_addr_en = 1'b0;
    pio_opcode = 8'h06;
    pio_len = 10'h000;
    pio_go();
    wait_done();
    chk("enable bits", 0, dbits);
    for (int i = 0; i < BUF_WORDS; i++) begin
      stage_wr_en = 1'b1;
      stage_wr_idx = 7'(i);
      stage_wr_data = {8'(i), 8'h3c, 8'(~i), 8'ha5};
      step(1);
    end
    stage_wr_en = 1'b0;
    pio_addr_en = 1'b1;
    pio_opcode = 8'h02;
    pio_addr = 32'h0000_2000;
    pio_len = PAGE_LEN;
    pio_go();
    wait_done();
    chk("prog cmd", 32'h0000_0002, 32'(cmd));
    chk("prog bits", 32'h0000_1000, dbits);
    chk("prog tail", 32'hA580_3C7F, wsh);
    pio_prog = 1'b0;
  endtask
  task automatic complete_run();
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  initial begin
    {arst_n, cfg_addr4, pio_start, pio_prog, stage_wr_en, dma_start, dr_req, out_ready} = '0;
    {pio_opcode, pio_addr, pio_len, stage_wr_idx, stage_wr_data, dma_src} = '0;
    {dma_dst_start, dma_dst_end, dr_addr, dr_words_m1, abits} = '0;
    pio_addr_en = 1'b1;
    cfg_rd_mode = RD_SINGLE;
    alanes = LANE1;
    dlanes = LANE1;
    step(20);
    arst_n = 1'b1;
    step(2);
    chk("idle select", 1, flash.cs_n);
    t_pio_read();
    t_modes();
    t_arb();
    t_prog();
    complete_run();
  end
endmodule
